//--- core/redriver_cfg_pkg.sv
// Package for the redriver serial configuration target: register map, field layout, bus timing.
// Assumes a single 10 MHz core clock; the serial bus pins are sampled, not used as clocks.
package redriver_cfg_pkg;

    // Register indices (one byte each)
    localparam logic [2:0] REG_RESERVED_FIRST = 3'h0;
    localparam logic [2:0] REG_RESERVED_SECOND = 3'h1;
    localparam logic [2:0] REG_LANE_POWER_DOWN = 3'h2;
    localparam logic [2:0] REG_LANE0_TUNING = 3'h3;
    localparam logic [2:0] REG_LANE1_TUNING = 3'h4;
    localparam logic [2:0] REG_LANE2_TUNING = 3'h5;
    localparam logic [2:0] REG_LANE3_TUNING = 3'h6;
    localparam logic [2:0] REG_RESERVED_LAST = 3'h7;
    localparam int NUM_LANES = 4;
    localparam int NUM_REGS = 8;

    // Reset values
    localparam logic [7:0] LANE_POWER_DOWN_RESET = 8'h00;
    localparam logic [7:0] LANE_TUNING_RESET = 8'h00;
    localparam logic [7:0] RESERVED_READ_VALUE = 8'h00;

    // Field positions
    localparam int PD_LANE0_BIT = 4;
    localparam int EQ_LSB = 4;
    localparam int FG_LSB = 2;
    localparam int SW_LSB = 0;

    // Address byte: fixed upper pattern, strap bits below
    localparam logic [2:0] ADDR_FIXED_BITS = 3'h7;
    localparam logic DIR_READ = 1'b1;

    // Bus timing
    localparam int CORE_CLK_HZ = 10_000_000;
    localparam int BUS_RATE_BPS = 100_000;
    localparam int CLK_PER_BUS_BIT = CORE_CLK_HZ / BUS_RATE_BPS;

    typedef struct packed {
        logic [3:0] eq_boost_code;
        logic [1:0] flat_gain_code;
        logic [1:0] output_swing_code;
    } lane_cfg_s;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_ACK = 6'b000100,
        ST_WRITE = 6'b001000,
        ST_READ = 6'b010000,
        ST_RACK = 6'b100000
    } bus_state_e;

endpackage : redriver_cfg_pkg

//--- core/redriver_i2c_config_slave.sv
// Serial-bus target and configuration registers for a four-lane linear redriver.
// Assumes scl and sda arrive asynchronously from pins and are oversampled by core_clk,
// and that the pad ring resolves the open-drain sda from sda_oe.
`timescale 1ns/1ps

module redriver_i2c_config_slave (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic serial_config_select,
    input wire logic cfg_reset_n,
    input wire logic cable_present_n,
    input wire logic [3:0] addr_strap,
    input wire redriver_cfg_pkg::lane_cfg_s strap_lane_cfg,
    output redriver_cfg_pkg::lane_cfg_s lane_cfg [redriver_cfg_pkg::NUM_LANES],
    output logic [redriver_cfg_pkg::NUM_LANES-1:0] lane_power_down,
    output logic [7:0] lane_power_down_reg
);
    import redriver_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic scl_meta, scl_sync, scl_prev;
    logic sda_meta, sda_sync, sda_prev;
    logic sel_meta, sel_sync;
    logic rstn_meta, rstn_sync;
    logic prs_meta, prs_sync;
    logic [3:0] strap_meta, strap_sync;
    lane_cfg_s strap_cfg_meta, strap_cfg_sync;

    // Two flops per pin, plus a third on scl and sda for edge detection; the first stage feeds no logic
    always_ff @(posedge core_clk) begin
        if (srst) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
            sel_meta <= 1'b0;
            sel_sync <= 1'b0;
            rstn_meta <= 1'b0;
            rstn_sync <= 1'b0;
            prs_meta <= 1'b1;
            prs_sync <= 1'b1;
            strap_meta <= 4'h0;
            strap_sync <= 4'h0;
            strap_cfg_meta <= '0;
            strap_cfg_sync <= '0;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
            sel_meta <= serial_config_select;
            sel_sync <= sel_meta;
            rstn_meta <= cfg_reset_n;
            rstn_sync <= rstn_meta;
            prs_meta <= cable_present_n;
            prs_sync <= prs_meta;
            strap_meta <= addr_strap;
            strap_sync <= strap_meta;
            strap_cfg_meta <= strap_lane_cfg;
            strap_cfg_sync <= strap_cfg_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus conditions

    logic scl_rise, scl_fall, start_seen, stop_seen;

    // Oversampling at 100x the bit rate leaves ample margin for edge detection
    assign scl_rise = scl_sync & ~scl_prev;
    assign scl_fall = ~scl_sync & scl_prev;
    assign start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
    assign stop_seen = scl_sync & scl_prev & ~sda_prev & sda_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Byte engine

    bus_state_e state;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic [2:0] byte_index;
    logic is_read;
    logic ack_drive;
    logic write_strobe;
    logic [7:0] read_byte;
    logic addr_match;
    logic addr_full;

    // Checked once all eight address bits are in: fixed pattern on top, straps below, direction last
    assign addr_match = (shift[7:5] == ADDR_FIXED_BITS) && (shift[4:1] == strap_sync);

    // Target-only: scl is never driven, transfers are never begun here
    assign scl_out = 1'b0;
    assign scl_oe = 1'b0;
    assign sda_out = 1'b0;

    // Bit and byte sequencing; shift register gathers eight bits per byte
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
            shift <= 8'h00;
            byte_index <= 3'h0;
            is_read <= 1'b0;
            ack_drive <= 1'b0;
            write_strobe <= 1'b0;
            addr_full <= 1'b0;
        end else begin
            write_strobe <= 1'b0;
            if (start_seen) begin
                state <= ST_ADDR;
                bit_cnt <= 3'h0;
                addr_full <= 1'b0;
                byte_index <= REG_RESERVED_FIRST;
                ack_drive <= 1'b0;
            end else if (stop_seen) begin
                state <= ST_IDLE; // Earlier completed bytes stay written
                ack_drive <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        ack_drive <= 1'b0;
                    end
                    ST_ADDR: begin
                        // Count on the rise: the clock fall that closes the start carries no bit,
                        // so counting falls here would judge the address one bit early
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_sync};
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                addr_full <= 1'b1;
                            end
                        end
                        if (scl_fall && addr_full) begin
                            addr_full <= 1'b0;
                            // Register access is only answered with select high
                            if (addr_match && sel_sync) begin
                                is_read <= (shift[0] == DIR_READ);
                                ack_drive <= 1'b1;
                                state <= ST_ACK;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            ack_drive <= 1'b0;
                            bit_cnt <= 3'h0;
                            if (is_read) begin
                                shift <= read_byte;
                                state <= ST_READ;
                            end else begin
                                state <= ST_WRITE;
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_sync};
                        end
                        if (scl_fall) begin
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                write_strobe <= 1'b1; // Byte complete, commit
                                ack_drive <= 1'b1;
                                state <= ST_ACK;
                            end
                        end
                    end
                    ST_READ: begin
                        if (scl_fall) begin
                            bit_cnt <= bit_cnt + 3'h1;
                            shift <= {shift[6:0], 1'b0};
                            if (bit_cnt == 3'h7) begin
                                byte_index <= byte_index + 3'h1;
                                state <= ST_RACK;
                            end
                        end
                    end
                    ST_RACK: begin
                        // Controller nack ends the read; ack continues with next byte
                        if (scl_rise && sda_sync) begin
                            state <= ST_IDLE;
                        end else if (scl_fall) begin
                            bit_cnt <= 3'h0;
                            shift <= read_byte;
                            state <= ST_READ;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
                if (write_strobe) begin
                    byte_index <= byte_index + 3'h1; // Index wraps past the last byte
                end
            end
        end
    end

    // Open-drain data: drive low for ack or for a zero read bit
    assign sda_oe = ack_drive | ((state == ST_READ) & ~shift[7]);

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0] power_down_reg;
    lane_cfg_s tuning_reg [NUM_LANES];

    // Writes land only while selected; low cfg reset forces defaults
    always_ff @(posedge core_clk) begin
        if (srst || !rstn_sync) begin
            power_down_reg <= LANE_POWER_DOWN_RESET;
            for (int i = 0; i < NUM_LANES; i++) begin
                tuning_reg[i] <= LANE_TUNING_RESET;
            end
        end else if (write_strobe && sel_sync) begin
            if (byte_index == REG_LANE_POWER_DOWN) begin
                power_down_reg <= shift; // Low nibble kept as plain storage
            end else if (byte_index == REG_LANE0_TUNING) begin
                tuning_reg[0] <= shift;
            end else if (byte_index == REG_LANE1_TUNING) begin
                tuning_reg[1] <= shift;
            end else if (byte_index == REG_LANE2_TUNING) begin
                tuning_reg[2] <= shift;
            end else if (byte_index == REG_LANE3_TUNING) begin
                tuning_reg[3] <= shift;
            end
            // Reserved bytes swallow the write
        end
    end

    // Read mux; reserved and unlisted bytes read as zero
    always_comb begin
        if (byte_index == REG_LANE_POWER_DOWN) begin
            read_byte = power_down_reg;
        end else if (byte_index == REG_LANE0_TUNING) begin
            read_byte = tuning_reg[0];
        end else if (byte_index == REG_LANE1_TUNING) begin
            read_byte = tuning_reg[1];
        end else if (byte_index == REG_LANE2_TUNING) begin
            read_byte = tuning_reg[2];
        end else if (byte_index == REG_LANE3_TUNING) begin
            read_byte = tuning_reg[3];
        end else begin
            read_byte = RESERVED_READ_VALUE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lane outputs

    // Registered outputs; straps override registers while select is low.
    // Cable absent powers every lane down; the register settings apply again after reconnect.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            lane_power_down <= '1;
            lane_power_down_reg <= 8'h00;
            for (int i = 0; i < NUM_LANES; i++) begin
                lane_cfg[i] <= '0;
            end
        end else begin
            lane_power_down_reg <= power_down_reg;
            for (int i = 0; i < NUM_LANES; i++) begin
                if (sel_sync) begin
                    lane_cfg[i] <= tuning_reg[i];
                    lane_power_down[i] <= prs_sync | power_down_reg[PD_LANE0_BIT + i];
                end else begin
                    lane_cfg[i] <= strap_cfg_sync;
                    lane_power_down[i] <= prs_sync;
                end
            end
        end
    end

endmodule : redriver_i2c_config_slave

//--- sim/redriver_i2c_config_slave_properties.sv
// Checker for the redriver serial configuration target.
// Bound onto the top module; sees only its ports, one core clock domain.
`timescale 1ns/1ps
module redriver_i2c_config_slave_properties (
    input logic core_clk,
    input logic srst,
    input logic scl_in,
    input logic scl_oe,
    input logic sda_out,
    input logic sda_oe,
    input logic serial_config_select,
    input logic cfg_reset_n,
    input logic cable_present_n,
    input redriver_cfg_pkg::lane_cfg_s strap_lane_cfg,
    input redriver_cfg_pkg::lane_cfg_s lane_cfg [redriver_cfg_pkg::NUM_LANES],
    input logic [redriver_cfg_pkg::NUM_LANES-1:0] lane_power_down,
    input logic [7:0] lane_power_down_reg
);
    import redriver_cfg_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // All checks share the core clock and its reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    chk_scl_released: assert property (!scl_oe)
        else $error("target drove the bus clock");
    chk_sda_open_drain: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    // Changing data under a high clock would fake a frame edge
    chk_no_false_frame: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data moved while bus clock high");
    chk_quiet_after_reset: assert property ($past(srst) |-> !sda_oe [*3])
        else $error("data pulled right after reset");
    chk_cable_absent: assert property (cable_present_n [*5] |-> lane_power_down == 4'hf)
        else $error("lanes up with cable absent");
    chk_pd_lane_map: assert property ((serial_config_select && !cable_present_n && $stable(lane_power_down_reg)) [*6]
        |-> lane_power_down == lane_power_down_reg[7:4])
        else $error("power-down bits mapped wrongly");
    chk_strap_mode: assert property ((!serial_config_select && $stable(strap_lane_cfg)) [*6]
        |-> lane_cfg[0] == strap_lane_cfg && lane_cfg[3] == strap_lane_cfg)
        else $error("lanes ignore straps");
    chk_cfg_clear: assert property (!cfg_reset_n [*5] |-> lane_power_down_reg == 8'h00)
        else $error("config reset did not clear");
endmodule : redriver_i2c_config_slave_properties

//--- sim/i2c_ctrl_model.sv
// Behavioural serial bus controller: drives the bus clock, pulls data low.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module i2c_ctrl_model (
    input logic sda,
    output logic scl,
    output logic sda_low
);
    // Bus clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // 800 ns bit; low phase 400 ns so the target's late ack settles before the rise
    task automatic bit_x(input logic b, output logic s);
        #200 sda_low = !b;
        #200 scl = 1'b1;
        #200 s = sda;
        #200 scl = 1'b0;
    endtask : bit_x
    // Frame edges, only with the clock high; the 10 ns skew keeps pin moves off core clock edges
    task automatic start();
        #10;
        sda_low = 1'b0;
        #200 scl = 1'b1;
        #200 sda_low = 1'b1;
        #200 scl = 1'b0;
    endtask : start
    task automatic stop();
        #200 sda_low = 1'b1;
        #200 scl = 1'b1;
        #200 sda_low = 1'b0;
        #200;
    endtask : stop
    // Whole bytes, most significant bit first
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
        end
        bit_x(1'b1, s);
        ack = !s;
    endtask : put
    task automatic get(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, d[i]);
        end
        bit_x(last, s);
    endtask : get
endmodule : i2c_ctrl_model

//--- sim/redriver_i2c_config_slave_tb.sv
// Self-checking bench for the redriver serial configuration target.
// Assumes the controller model on a pulled-up data line.
`timescale 1ns/1ps
module redriver_i2c_config_slave_tb;
    import redriver_cfg_pkg::*;
    typedef struct packed {
        logic [7:0] w;
        logic [7:0] r;
    } row_s;
    logic core_clk = 1'b0;
    logic srst, serial_config_select, cfg_reset_n, cable_present_n, scl, sda_low, sda_oe, sda, ack;
    logic [3:0] addr_strap, tgt, lane_power_down;
    logic [7:0] lane_power_down_reg;
    logic [7:0] wdat [8];
    logic [7:0] rdat [8];
    lane_cfg_s strap_lane_cfg;
    lane_cfg_s lane_cfg [NUM_LANES];
    int errors = 0, tests_run = 0, cycles = 0;
    // Reserved bytes read zero whatever was written
    row_s rows [8] = '{'{8'ha5, 8'h00}, '{8'h3c, 8'h00}, '{8'h5a, 8'h5a}, '{8'h1b, 8'h1b},
        '{8'hc6, 8'hc6}, '{8'he9, 8'he9}, '{8'h72, 8'h72}, '{8'hff, 8'h00}};
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, wired-and data line, hang guard
    always #50 core_clk = ~core_clk;
    assign sda = !(sda_low || sda_oe);
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end
    redriver_i2c_config_slave i_dut (.core_clk(core_clk), .srst(srst), .scl_in(scl), .scl_out(),
        .scl_oe(), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .serial_config_select(serial_config_select),
        .cfg_reset_n(cfg_reset_n), .cable_present_n(cable_present_n), .addr_strap(addr_strap),
        .strap_lane_cfg(strap_lane_cfg), .lane_cfg(lane_cfg), .lane_power_down(lane_power_down),
        .lane_power_down_reg(lane_power_down_reg));
    i2c_ctrl_model i_ctrl (.sda(sda), .scl(scl), .sda_low(sda_low));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    // Index restarts at the lowest byte on every frame
    task automatic wr(input int n, output logic a0);
        logic a;
        i_ctrl.start();
        i_ctrl.put({ADDR_FIXED_BITS, tgt, 1'b0}, a0);
        for (int i = 0; i < n; i++) begin
            i_ctrl.put(wdat[i], a);
        end
        i_ctrl.stop();
        repeat (5) @(posedge core_clk);
    endtask : wr
    task automatic rd(input int n, output logic a0);
        i_ctrl.start();
        i_ctrl.put({ADDR_FIXED_BITS, tgt, DIR_READ}, a0);
        for (int i = 0; i < n; i++) begin
            i_ctrl.get(i == n - 1, rdat[i]);
        end
        i_ctrl.stop();
        repeat (5) @(posedge core_clk);
    endtask : rd
    task automatic test_done();
        $display("checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        serial_config_select = 1'b1;
        cfg_reset_n = 1'b1;
        cable_present_n = 1'b0;
        addr_strap = 4'h5;
        tgt = 4'h5;
        strap_lane_cfg = 8'h9e;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd(8, ack);
        check("addr ack", 8'h01, {7'h0, ack});
        for (int i = 0; i < 8; i++) begin
            check("reset byte", 8'h00, rdat[i]);
            wdat[i] = rows[i].w;
        end
        wr(8, ack);
        rd(8, ack);
        for (int i = 0; i < 8; i++) begin
            check("read back", rows[i].r, rdat[i]);
        end
        for (int k = 0; k < NUM_LANES; k++) begin
            check("lane cfg", rows[3 + k].w, lane_cfg[k]);
        end
        check("power down", 8'h05, {4'h0, lane_power_down});
        $display("register table test done");
        // Stop after byte 2; later bytes must be untouched
        wdat[2] = 8'h77;
        wr(3, ack);
        rd(3, ack);
        check("early stop", 8'h77, rdat[2]);
        check("lane0 kept", rows[3].w, lane_cfg[0]);
        wdat[2] = 8'h33;
        tgt = 4'h6;
        wr(3, ack);
        check("wrong addr", 8'h00, {7'h0, ack});
        addr_strap <= 4'h6;
        repeat (4) @(posedge core_clk);
        rd(3, ack);
        check("strap addr", 8'h01, {7'h0, ack});
        check("wrong addr write", 8'h77, rdat[2]);
        $display("address test done");
        serial_config_select <= 1'b0;
        wr(3, ack);
        check("select low ack", 8'h00, {7'h0, ack});
        check("strap lanes", strap_lane_cfg, lane_cfg[2]);
        serial_config_select <= 1'b1;
        repeat (5) @(posedge core_clk);
        rd(3, ack);
        check("select low write", 8'h77, rdat[2]);
        $display("select test done");
        cable_present_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        check("cable absent", 8'h0f, {4'h0, lane_power_down});
        cable_present_n <= 1'b0;
        wr(3, ack);
        check("cable back", 8'h03, {4'h0, lane_power_down});
        cfg_reset_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        cfg_reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        check("cfg reset", 8'h00, lane_power_down_reg);
        check("cfg reset lane", 8'h00, lane_cfg[1]);
        srst <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("srst power down", 8'h0f, {4'h0, lane_power_down});
        srst <= 1'b0;
        repeat (3) @(posedge core_clk);
        $display("reset test done");
        test_done();
    end
endmodule : redriver_i2c_config_slave_tb
bind redriver_i2c_config_slave redriver_i2c_config_slave_properties i_props (.core_clk(core_clk),
    .srst(srst), .scl_in(scl_in), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .serial_config_select(serial_config_select), .cfg_reset_n(cfg_reset_n),
    .cable_present_n(cable_present_n), .strap_lane_cfg(strap_lane_cfg), .lane_cfg(lane_cfg),
    .lane_power_down(lane_power_down), .lane_power_down_reg(lane_power_down_reg));
